/* hdl/tsc_tamper_cal.sv */
// dual-channel tamper selector and serial calibration loader
//
// Notes on behaviour
// - Two current channels, phase and neutral, are accumulated separately per period.
// - On tamper, metering switches to the channel with the larger load current.
// - Tamper is declared when the two sums differ by eight percent or more.
// - In single-sensor configuration no tamper detection is done.
// - A bypass option disables comparison and pins metering to one channel.
// - Default calibration constants are held from reset until new ones load.
// - Four gain constants: per channel, per low and high amplifier gain.
// - A phase timing correction arrives with the gains and is driven out on phase_corr.
// - Downloads are accepted only while the calibration jumper is asserted.
// - Received calibration data is written into nonvolatile memory.
// - The comparison uses the same per-period sums as gain selection.
// - A tamper indication output is raised when tamper is detected.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module tsc_tamper_cal
  import tsc_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // current samples, same clock domain
  input wire logic [SAMPLE_W-1:0] current_sensor_a,
  input wire logic [SAMPLE_W-1:0] current_sensor_b,
  input wire logic sample_valid,
  input wire logic period_end,
  input wire logic amp_high_gain,
  // pins
  input wire logic calibration_enable_jumper,
  input wire logic cal_rxd,
  // metering results
  output logic meter_sel_phase,
  output logic tamper_out,
  output logic [CONST_W-1:0] gain_const,
  output logic [CONST_W-1:0] phase_corr,
  output logic [ACC_W-1:0] gain_sum,
  output logic gain_sum_valid,
  // nonvolatile memory write port
  output logic nvm_we,
  output logic [CAL_IDX_W:0] nvm_addr,
  output logic [7:0] nvm_wdata,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // interrupt
  output logic irq
);

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [1:0] jp_sync_reg, rx_sync_reg;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      jp_sync_reg <= 2'b00;
      rx_sync_reg <= 2'b11; // idle line is high
    end
    else
    begin
      jp_sync_reg <= {jp_sync_reg[0], calibration_enable_jumper};
      rx_sync_reg <= {rx_sync_reg[0], cal_rxd};
    end
  end
  logic jp_on;
  assign jp_on = jp_sync_reg[1];

  logic [7:0] rx_byte;
  logic rx_vld, rx_err;
  tsc_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .ref_clk(ref_clk),
    .rst(rst),
    .rxd(rx_sync_reg[1]),
    .rx_data(rx_byte),
    .rx_valid(rx_vld),
    .rx_frame_err(rx_err)
  );

  // --------------------------------------------------------------
  // state declarations
  // --------------------------------------------------------------
  logic [ACC_W-1:0] acc_a_reg, acc_a_next, acc_b_reg, acc_b_next;
  logic [ACC_W-1:0] sum_a_reg, sum_a_next, sum_b_reg, sum_b_next;
  logic cmp_reg, cmp_next;
  tsc_sel_t sel_reg, sel_next;
  logic tamper_reg, tamper_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic [IRQ_W-1:0] ist_reg, ist_next, imask_reg, imask_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [CONST_W-1:0] cal_reg [CAL_WORDS];
  logic [CONST_W-1:0] cal_next [CAL_WORDS];
  logic [CONST_W-1:0] stage_reg [CAL_WORDS];
  logic [CONST_W-1:0] stage_next [CAL_WORDS];
  logic loading_reg, loading_next;
  logic [CAL_IDX_W:0] bcnt_reg, bcnt_next;
  logic nvm_we_reg, nvm_we_next;
  logic [CAL_IDX_W:0] nvm_addr_reg, nvm_addr_next;
  logic [7:0] nvm_wdata_reg, nvm_wdata_next;

  // absolute value of a signed sample, shared by both channels
  function automatic logic [ACC_W-1:0] mag(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] m;
    m = s[SAMPLE_W-1] ? (~s + 1'b1) : s;
    mag = ACC_W'(m);
  endfunction : mag

  // difference >= 8% of the heavier leg, scaled to avoid a divider
  function automatic logic over_thresh(input logic [ACC_W-1:0] hi,
                                       input logic [ACC_W-1:0] lo);
    logic [ACC_W+7:0] l, r;
    l = (ACC_W+8)'(hi - lo) * (ACC_W+8)'(100);
    r = (ACC_W+8)'(hi) * (ACC_W+8)'(THRESH_PCT);
    over_thresh = (l >= r) && (hi != '0);
  endfunction : over_thresh

  // --------------------------------------------------------------
  // accumulation and tamper decision
  // --------------------------------------------------------------
  logic a_heavier, diff_hit, cmp_en;
  assign a_heavier = sum_a_reg >= sum_b_reg;
  assign diff_hit = a_heavier ? over_thresh(sum_a_reg, sum_b_reg)
                              : over_thresh(sum_b_reg, sum_a_reg);
  assign cmp_en = !ctrl_reg[CTRL_SINGLE_BIT] && !ctrl_reg[CTRL_BYPASS_BIT];

  always_comb
  begin
    acc_a_next = acc_a_reg;
    acc_b_next = acc_b_reg;
    sum_a_next = sum_a_reg;
    sum_b_next = sum_b_reg;
    cmp_next = 1'b0;
    sel_next = sel_reg;
    tamper_next = tamper_reg;
    if (sample_valid)
    begin
      acc_a_next = acc_a_reg + mag(current_sensor_a);
      acc_b_next = acc_b_reg + mag(current_sensor_b);
    end
    if (period_end)
    begin
      // the same period sums feed gain selection and comparison
      sum_a_next = sample_valid ? acc_a_next : acc_a_reg;
      sum_b_next = sample_valid ? acc_b_next : acc_b_reg;
      acc_a_next = '0;
      acc_b_next = '0;
      cmp_next = 1'b1;
    end
    if (!cmp_en)
    begin
      // single channel or bypass: fixed channel, no tamper
      sel_next = SEL_NEUTRAL;
      tamper_next = 1'b0;
    end
    else if (cmp_reg)
    begin
      tamper_next = diff_hit;
      if (diff_hit)
        sel_next = a_heavier ? SEL_PHASE : SEL_NEUTRAL;
      else
        sel_next = SEL_NEUTRAL;
    end
  end

  // --------------------------------------------------------------
  // calibration receive: start byte then low/high byte pairs
  // --------------------------------------------------------------
  always_comb
  begin
    loading_next = loading_reg;
    bcnt_next = bcnt_reg;
    nvm_we_next = 1'b0;
    nvm_addr_next = nvm_addr_reg;
    nvm_wdata_next = nvm_wdata_reg;
    for (int i = 0; i < CAL_WORDS; i++)
    begin
      cal_next[i] = cal_reg[i];
      stage_next[i] = stage_reg[i];
    end
    if (!jp_on)
      loading_next = 1'b0;
    else if (rx_vld)
    begin
      if (!loading_reg)
      begin
        if (rx_byte == CAL_START_BYTE)
        begin
          loading_next = 1'b1;
          bcnt_next = '0;
        end
      end
      else
      begin
        if (bcnt_reg[0])
          stage_next[bcnt_reg[CAL_IDX_W:1]][15:8] = rx_byte;
        else
          stage_next[bcnt_reg[CAL_IDX_W:1]][7:0] = rx_byte;
        nvm_we_next = 1'b1;
        nvm_addr_next = bcnt_reg;
        nvm_wdata_next = rx_byte;
        bcnt_next = bcnt_reg + 1'b1;
        if (bcnt_reg == (CAL_IDX_W+1)'(CAL_BYTES - 1))
        begin
          loading_next = 1'b0;
          // commit all constants at once so no half set is used
          for (int i = 0; i < CAL_WORDS; i++)
            cal_next[i] = stage_next[i];
        end
      end
    end
  end

  // --------------------------------------------------------------
  // register port and interrupt status
  // --------------------------------------------------------------
  logic cal_done_ev;
  assign cal_done_ev = nvm_we_next && !loading_next && jp_on;
  logic [IRQ_W-1:0] ev;
  assign ev = {rx_err && jp_on, cal_done_ev, tamper_next && !tamper_reg};

  always_comb
  begin
    ctrl_next = ctrl_reg;
    imask_next = imask_reg;
    ist_next = ist_reg;
    rdata_next = '0;
    if (reg_wr)
    begin
      if (reg_addr == OFF_CTRL)
        ctrl_next = reg_wdata[1:0];
      else if (reg_addr == OFF_IRQ_STAT)
        ist_next = ist_reg & ~reg_wdata[IRQ_W-1:0];
      else if (reg_addr == OFF_IRQ_MASK)
        imask_next = reg_wdata[IRQ_W-1:0];
    end
    ist_next = ist_next | ev; // set wins over clear
    if (reg_rd)
    begin
      if (reg_addr == OFF_CTRL)
        rdata_next = DATA_W'(ctrl_reg);
      else if (reg_addr == OFF_STATUS)
        rdata_next = DATA_W'({loading_reg, jp_on, sel_reg == SEL_PHASE, tamper_reg});
      else if (reg_addr == OFF_IRQ_STAT)
        rdata_next = DATA_W'(ist_reg);
      else if (reg_addr == OFF_IRQ_MASK)
        rdata_next = DATA_W'(imask_reg);
      else if (reg_addr == OFF_ACC_A)
        rdata_next = sum_a_reg[ACC_W-1 -: DATA_W];
      else if (reg_addr == OFF_ACC_B)
        rdata_next = sum_b_reg[ACC_W-1 -: DATA_W];
      else if (reg_addr >= OFF_CAL_BASE && reg_addr < OFF_CAL_BASE + 8'(4 * CAL_WORDS)
               && reg_addr[1:0] == 2'b00)
        rdata_next = cal_reg[3'(reg_addr[4:2])];
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      acc_a_reg <= '0;
      acc_b_reg <= '0;
      sum_a_reg <= '0;
      sum_b_reg <= '0;
      cmp_reg <= 1'b0;
      sel_reg <= SEL_NEUTRAL;
      tamper_reg <= 1'b0;
      ctrl_reg <= CTRL_RESET;
      ist_reg <= '0;
      imask_reg <= '0;
      rdata_reg <= '0;
      loading_reg <= 1'b0;
      bcnt_reg <= '0;
      nvm_we_reg <= 1'b0;
      nvm_addr_reg <= '0;
      nvm_wdata_reg <= '0;
      for (int i = 0; i < CAL_WORDS; i++)
      begin
        cal_reg[i] <= (i == CAL_PHASE_IDX) ? PHASE_DEFAULT : GAIN_DEFAULT;
        stage_reg[i] <= '0;
      end
    end
    else
    begin
      acc_a_reg <= acc_a_next;
      acc_b_reg <= acc_b_next;
      sum_a_reg <= sum_a_next;
      sum_b_reg <= sum_b_next;
      cmp_reg <= cmp_next;
      sel_reg <= sel_next;
      tamper_reg <= tamper_next;
      ctrl_reg <= ctrl_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      rdata_reg <= rdata_next;
      loading_reg <= loading_next;
      bcnt_reg <= bcnt_next;
      nvm_we_reg <= nvm_we_next;
      nvm_addr_reg <= nvm_addr_next;
      nvm_wdata_reg <= nvm_wdata_next;
      for (int i = 0; i < CAL_WORDS; i++)
      begin
        cal_reg[i] <= cal_next[i];
        stage_reg[i] <= stage_next[i];
      end
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  logic [1:0] gidx;
  // gain index: bit1 = channel, bit0 = high gain
  assign gidx = {sel_reg == SEL_PHASE, amp_high_gain};
  assign gain_const = cal_reg[gidx];
  assign phase_corr = cal_reg[CAL_PHASE_IDX];
  assign meter_sel_phase = (sel_reg == SEL_PHASE);
  assign tamper_out = tamper_reg;
  assign gain_sum = (sel_reg == SEL_PHASE) ? sum_a_reg : sum_b_reg;
  assign gain_sum_valid = cmp_reg;
  assign nvm_we = nvm_we_reg;
  assign nvm_addr = nvm_addr_reg;
  assign nvm_wdata = nvm_wdata_reg;
  assign reg_rdata = rdata_reg;
  assign irq = |(ist_reg & imask_reg);

endmodule : tsc_tamper_cal

/* hdl/tsc_pkg.sv */
// package of constants and types for the tamper select and calibration loader
package tsc_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int SAMPLE_W = 12;
  localparam int ACC_W = 24;
  localparam int CONST_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;

  // ---------------------------------------------------------------
  // tamper threshold, percent of the heavier leg
  // ---------------------------------------------------------------
  localparam int THRESH_PCT = 8;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_ACC_A = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ACC_B = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CAL_BASE = 8'h20;

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int CTRL_SINGLE_BIT = 0;
  localparam int CTRL_BYPASS_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // interrupt bits
  localparam int IRQ_TAMPER_BIT = 0;
  localparam int IRQ_CAL_DONE_BIT = 1;
  localparam int IRQ_FRAME_ERR_BIT = 2;
  localparam int IRQ_W = 3;

  // ---------------------------------------------------------------
  // calibration constants: 0..3 gains, 4 phase correction
  // ---------------------------------------------------------------
  localparam int CAL_WORDS = 5;
  localparam int CAL_BYTES = CAL_WORDS * 2;
  localparam int CAL_IDX_W = 3;
  localparam int CAL_PHASE_IDX = 4;
  localparam logic [CONST_W-1:0] GAIN_DEFAULT = 16'h00c8;
  localparam logic [CONST_W-1:0] PHASE_DEFAULT = 16'h0000;
  localparam logic [7:0] CAL_START_BYTE = 8'h5a;

  typedef enum logic {SEL_NEUTRAL, SEL_PHASE} tsc_sel_t;

endpackage : tsc_pkg

/* hdl/tsc_uart_rx.sv */
// serial byte receiver, 8 data bits, no parity, one stop bit
`timescale 1ns/1ns
module tsc_uart_rx
  import tsc_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial line, already synchronised
  input wire logic rxd,
  // received byte
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_err
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} tsc_rx_state_t;

  tsc_rx_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] shf_reg, shf_next;
  logic [7:0] data_reg, data_next;
  logic vld_reg, vld_next;
  logic err_reg, err_next;

  // --------------------------------------------------------------
  // next state: sample each bit at its middle
  // --------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    shf_next = shf_reg;
    data_next = data_reg;
    vld_next = 1'b0;
    err_next = 1'b0;
    case (state_reg)
      RX_IDLE:
      begin
        if (!rxd)
        begin
          state_next = RX_START;
          cnt_next = 16'(BIT_CYC / 2);
        end
      end
      RX_START:
      begin
        if (cnt_reg != 16'h0000)
          cnt_next = cnt_reg - 16'h0001;
        else if (rxd)
          state_next = RX_IDLE; // glitch, not a start bit
        else
        begin
          state_next = RX_DATA;
          cnt_next = 16'(BIT_CYC - 1);
          bit_next = 3'h0;
        end
      end
      RX_DATA:
      begin
        if (cnt_reg != 16'h0000)
          cnt_next = cnt_reg - 16'h0001;
        else
        begin
          shf_next = {rxd, shf_reg[7:1]};
          cnt_next = 16'(BIT_CYC - 1);
          bit_next = bit_reg + 3'h1;
          if (bit_reg == 3'h7)
            state_next = RX_STOP;
        end
      end
      default:
      begin
        if (cnt_reg != 16'h0000)
          cnt_next = cnt_reg - 16'h0001;
        else
        begin
          state_next = RX_IDLE;
          if (rxd)
          begin
            data_next = shf_reg;
            vld_next = 1'b1;
          end
          else
            err_next = 1'b1;
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= RX_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 3'h0;
      shf_reg <= 8'h00;
      data_reg <= 8'h00;
      vld_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      shf_reg <= shf_next;
      data_reg <= data_next;
      vld_reg <= vld_next;
      err_reg <= err_next;
    end
  end

  assign rx_data = data_reg;
  assign rx_valid = vld_reg;
  assign rx_frame_err = err_reg;

endmodule : tsc_uart_rx

/* tb/tsc_cal_host.sv */
// calibration host model: sends 8n1 bytes on the serial line
`timescale 1ns/1ns
module tsc_cal_host #(
  parameter int BIT_CYC = 16
)(
  // clock
  input wire logic ref_clk,
  // byte request from the bench
  input wire logic send,
  input wire logic [7:0] tx_byte,
  input wire logic [7:0] idle_gap,
  output logic busy,
  // serial line, idles high like a pulled-up line
  output logic txd
);
  logic [9:0] frame;

  // one frame per request, lsb first; idle_gap lets the host be slow
  initial
  begin
    txd = 1'b1;
    busy = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      if (send)
      begin
        busy <= 1'b1;
        frame = {1'b1, tx_byte, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
          txd <= frame[i];
          repeat (BIT_CYC) @(posedge ref_clk);
        end
        repeat (idle_gap) @(posedge ref_clk);
        busy <= 1'b0;
      end
    end
  end
endmodule : tsc_cal_host

/* tb/tsc_tamper_cal_properties.sv */
// checker of the tamper selector and calibration loader ports
`timescale 1ns/1ns
module tsc_tamper_cal_properties
  import tsc_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // watched ports
  input wire logic period_end,
  input wire logic calibration_enable_jumper,
  input wire logic meter_sel_phase,
  input wire logic tamper_out,
  input wire logic [CONST_W-1:0] phase_corr,
  input wire logic gain_sum_valid,
  input wire logic nvm_we,
  input wire logic [CAL_IDX_W:0] nvm_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // one-cycle pulses answering a period end or a stored byte
  sequence s_period_answer;
    gain_sum_valid ##1 !gain_sum_valid;
  endsequence
  sequence s_byte_stored;
    nvm_we ##1 !nvm_we;
  endsequence

  chk_sum_after_period: assert property (period_end |=> s_period_answer)
    else $error("period sums not flagged one cycle after period end");
  chk_sum_has_cause: assert property (gain_sum_valid |-> $past(period_end))
    else $error("period sums flagged without period end");
  chk_nvm_one_cycle: assert property (nvm_we |-> s_byte_stored)
    else $error("memory write strobe longer than one cycle");
  chk_nvm_addr_range: assert property (nvm_we |-> nvm_addr < CAL_BYTES)
    else $error("memory write outside calibration bytes");
  chk_nvm_needs_jumper: assert property (nvm_we |-> $past(calibration_enable_jumper, 3))
    else $error("memory written without calibration jumper");
  chk_phase_on_commit: assert property ($changed(phase_corr) |-> nvm_we || $past(nvm_we))
    else $error("phase correction changed outside a load");
  chk_phase_needs_tamper: assert property (meter_sel_phase |-> tamper_out)
    else $error("phase channel selected without tamper");
  // a decision only follows a period end, or a control write forcing neutral
  chk_decision_timing: assert property ($changed(tamper_out) || $changed(meter_sel_phase)
    |-> $past(period_end, 2) || $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("tamper decision changed without cause");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data present without a read");
endmodule : tsc_tamper_cal_properties

bind tsc_tamper_cal tsc_tamper_cal_properties #(.BIT_CYC(BIT_CYC)) i_props (
  .ref_clk(ref_clk), .rst(rst), .period_end(period_end),
  .calibration_enable_jumper(calibration_enable_jumper), .meter_sel_phase(meter_sel_phase),
  .tamper_out(tamper_out), .phase_corr(phase_corr), .gain_sum_valid(gain_sum_valid),
  .nvm_we(nvm_we), .nvm_addr(nvm_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));

/* tb/tb_tsc_tamper_cal.sv */
// testbench of the tamper selector and calibration loader
`timescale 1ns/1ns
module tb_tsc_tamper_cal;
  import tsc_pkg::*;
  localparam int BC = 16;
  logic ref_clk, rst, sample_valid, period_end, amp_high_gain, calibration_enable_jumper;
  logic reg_wr, reg_rd, send, busy, cal_rxd, meter_sel_phase, tamper_out, gain_sum_valid;
  logic nvm_we, irq;
  logic [SAMPLE_W-1:0] current_sensor_a, current_sensor_b;
  logic [CONST_W-1:0] gain_const, phase_corr;
  logic [ACC_W-1:0] gain_sum;
  logic [CAL_IDX_W:0] nvm_addr;
  logic [7:0] nvm_wdata, tx_byte, host_gap;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [15:0] cal [CAL_WORDS];
  int fails, check_count, nvm_cnt, aa, bb, hi, et, es;
  int ra[7] = '{-1000, 1000, 1000, 1000, 920, 1000, 0};
  int rb[7] = '{1000, 920, 500, 921, 1000, 500, 0};
  int rc[7] = '{0, 0, 1, 0, 0, 2, 0};

  tsc_tamper_cal #(.BIT_CYC(BC)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .current_sensor_a(current_sensor_a),
    .current_sensor_b(current_sensor_b), .sample_valid(sample_valid), .period_end(period_end),
    .amp_high_gain(amp_high_gain), .calibration_enable_jumper(calibration_enable_jumper),
    .cal_rxd(cal_rxd), .meter_sel_phase(meter_sel_phase), .tamper_out(tamper_out),
    .gain_const(gain_const), .phase_corr(phase_corr), .gain_sum(gain_sum),
    .gain_sum_valid(gain_sum_valid), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  tsc_cal_host #(.BIT_CYC(BC)) i_host (.ref_clk(ref_clk), .send(send), .tx_byte(tx_byte),
    .idle_gap(host_gap), .busy(busy), .txd(cal_rxd));

  // free-running clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0, got}, {15'h0, exp});
  endtask : chk_bit

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk_word(reg_rdata, exp);
  endtask : rd

  // wait on the host is bounded; a hung line ends the run
  task automatic host_byte(input logic [7:0] b);
    @(posedge ref_clk);
    send <= 1'b1;
    tx_byte <= b;
    @(posedge ref_clk);
    send <= 1'b0;
    @(posedge ref_clk); // busy rises on the edge where the host takes the request
    for (int i = 0; i < 12 * BC + 300 && busy !== 1'b0; i++)
      @(posedge ref_clk);
    if (busy !== 1'b0)
    begin
      fails++;
      print_verdict();
    end
  endtask : host_byte

  // four samples then a period end; decision is settled two cycles later
  task automatic period(input int a, input int b);
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    current_sensor_a <= 12'(a);
    current_sensor_b <= 12'(b);
    repeat (4) @(posedge ref_clk);
    sample_valid <= 1'b0;
    period_end <= 1'b1;
    @(posedge ref_clk);
    period_end <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : period

  // every memory write is compared with the byte sent for that index
  always @(posedge ref_clk)
    if (nvm_we === 1'b1)
    begin
      chk_word({12'h0, nvm_addr}, 16'(nvm_cnt));
      chk_word({8'h0, nvm_wdata}, {8'h0, cal[nvm_cnt / 2][8 * (nvm_cnt % 2) +: 8]});
      nvm_cnt++;
    end

  // main sequence
  initial
  begin
    {rst, sample_valid, period_end, amp_high_gain, calibration_enable_jumper} = 5'h10;
    {reg_wr, reg_rd, send, tx_byte, host_gap, reg_addr, reg_wdata} = '0;
    {current_sensor_a, current_sensor_b} = '0;
    for (int i = 0; i < CAL_WORDS; i++)
      cal[i] = 16'h2010 + 16'(i * 16'h0101);
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 chk_word(gain_const, GAIN_DEFAULT);
    chk_word(phase_corr, PHASE_DEFAULT);
    chk_bit(tamper_out, 1'b0);
    chk_bit(meter_sel_phase, 1'b0);
    for (int i = 0; i < CAL_WORDS; i++)
      rd(OFF_CAL_BASE + 8'(4 * i), i == CAL_PHASE_IDX ? PHASE_DEFAULT : GAIN_DEFAULT);
    rd(8'h40, 16'h0000);
    // jumper off: a start byte and three data bytes are ignored
    host_byte(CAL_START_BYTE);
    for (int k = 0; k < 3; k++)
      host_byte(8'h33);
    chk_word(16'(nvm_cnt), 16'h0000);
    chk_word(phase_corr, PHASE_DEFAULT);
    // jumper on, slow host: gains and phase word downloaded
    calibration_enable_jumper <= 1'b1;
    host_gap <= 8'h25;
    repeat (4) @(posedge ref_clk);
    host_byte(CAL_START_BYTE);
    for (int k = 0; k < CAL_BYTES; k++)
      host_byte(cal[k / 2][8 * (k % 2) +: 8]);
    repeat (4) @(posedge ref_clk);
    chk_word(16'(nvm_cnt), 16'(CAL_BYTES));
    chk_word(phase_corr, cal[CAL_PHASE_IDX]);
    for (int i = 0; i < CAL_WORDS; i++)
      rd(OFF_CAL_BASE + 8'(4 * i), cal[i]);
    rd(OFF_IRQ_STAT, 16'h0002);
    @(posedge ref_clk);
    amp_high_gain <= 1'b1;
    @(posedge ref_clk);
    #1 chk_word(gain_const, cal[1]);
    @(posedge ref_clk);
    amp_high_gain <= 1'b0;
    calibration_enable_jumper <= 1'b0;
    wr(OFF_IRQ_STAT, 16'h0007);
    // tamper table: boundary, both directions, single and bypass modes
    for (int r = 0; r < 7; r++)
    begin
      wr(OFF_CTRL, 16'(rc[r]));
      period(ra[r], rb[r]);
      aa = ra[r] < 0 ? -ra[r] : ra[r];
      bb = rb[r];
      hi = aa > bb ? aa : bb;
      et = rc[r] == 0 && hi != 0 && (aa > bb ? aa - bb : bb - aa) * 100 >= hi * 8;
      es = et && aa >= bb;
      chk_bit(tamper_out, et[0]);
      chk_bit(meter_sel_phase, es[0]);
      chk_word(gain_const, cal[{es[0], 1'b0}]);
      chk_word(gain_sum[15:0], 16'((es ? aa : bb) * 4));
      rd(OFF_STATUS, {14'h0, es[0], et[0]});
      rd(OFF_ACC_A, 16'((aa * 4) >> 8));
      rd(OFF_ACC_B, 16'((bb * 4) >> 8));
    end
    // tamper interrupt: sticky, masked, then cleared
    rd(OFF_IRQ_STAT, 16'h0001);
    chk_bit(irq, 1'b0);
    wr(OFF_IRQ_MASK, 16'h0001);
    @(posedge ref_clk);
    #1 chk_bit(irq, 1'b1);
    wr(OFF_IRQ_STAT, 16'h0001);
    @(posedge ref_clk);
    #1 chk_bit(irq, 1'b0);
    rd(OFF_IRQ_STAT, 16'h0000);
    print_verdict();
  end
endmodule : tb_tsc_tamper_cal
